/* File: hw/swp_ctrl.sv */
// sleep/wakeup power controller: power modes, wake sources, restart sequence
// assumes apb master on the register side and inputs synchronous to i_clk
//
// What this block does
// - three modes: active, sleep, deep sleep
// - cpu doze in active, any irq ends it
// - pins keep output and pullup while sleeping
// - optional ram retention, else ram off
// - slow osc may stop, restarts on wake
// - sleep wakes only on enabled six sources
// - pending wakes persist, software clears first
// - wake: supply check, fast osc, then cpu
// - status shows reset came from sleep
// - two 41-bit slow counters, keep counting
// - both counters run, also in sleep unless slow osc off
// - pin edge wake, selectable rising/falling
// - two 16-bit pulse counters, never stop
// - pulse counters wake without slow osc
// - deep sleep: domains off, slow osc off
// - deep exit by pin/comparator, cold start
// - comparator low-power edge wakes sleep
// - comparator input selects and hysteresis
// - comparator readable, can be disabled
// - logic and radio domains off in sleep
// - supply domain always on, parts switchable
`timescale 1ns/1ps
module swp_ctrl (
    input  wire logic                  i_clk,
    input  wire logic                  i_arst_n,
    input  wire swp_pkg::swp_apb_req_t i_apb,
    output logic                       o_pready,
    output logic                       o_pslverr,
    output logic [31:0]                o_prdata,
    input  wire logic [19:0]           i_gpio_in,
    output logic [19:0]                o_gpio_out,
    output logic [19:0]                o_gpio_pu,
    input  wire logic                  i_cmp_out,
    output swp_pkg::swp_cmp_cfg_t      o_cmp_cfg,
    input  wire logic [1:0]            i_pulse,
    input  wire logic                  i_irq_any,
    input  wire logic                  i_radio_req,
    input  wire logic                  i_svm_ok,
    input  wire logic                  i_frc_stable,
    output swp_pkg::swp_pwr_t          o_pwr
);
    import swp_pkg::*;

    swp_state_t r;
    swp_state_t n;
    logic       wr;
    logic       setup;
    logic       pend_clr;
    logic [5:0] ev;
    logic [19:0] pin_hit;
    logic       cmp_edge;
    logic       wake;

    always_comb
    begin
        n = r;
        setup = i_apb.psel && !i_apb.penable;
        wr = i_apb.psel && i_apb.penable && r.pready && i_apb.pwrite;
        pend_clr = wr && (i_apb.paddr == A_WAKE_PND);
        ev = '0;

        // slow tick only while the 32k oscillator is powered
        n.slow_tick = 1'b0;
        if (r.pwr.slow_on)
        begin
            n.div = (r.div == SLOW_DIV_LAST) ? 12'h000 : r.div + 12'h001;
            n.slow_tick = (r.div == SLOW_DIV_LAST);
        end

        if (r.slow_tick)
        begin
            n.t0 = r.t0 + 41'h1;
            n.t1 = r.t1 + 41'h1;
            ev[W_T0] = (r.t0 == r.tc0);
            ev[W_T1] = (r.t1 == r.tc1);
        end

        // pulse counters run off the raw input, no slow clock needed
        n.pc_prev = i_pulse;
        if (i_pulse[0] && !r.pc_prev[0])
        begin
            n.pc0 = r.pc0 + 16'h0001;
            ev[W_PC0] = (r.pc0 + 16'h0001 == r.pcc[15:0]);
        end
        if (i_pulse[1] && !r.pc_prev[1])
        begin
            n.pc1 = r.pc1 + 16'h0001;
            ev[W_PC1] = (r.pc1 + 16'h0001 == r.pcc[31:16]);
        end

        // edge detection stays live even when the pin serves another function
        n.pin_prev = i_gpio_in;
        pin_hit = r.pin_en & ((r.pin_rise & i_gpio_in & ~r.pin_prev)
                  | (~r.pin_rise & ~i_gpio_in & r.pin_prev));
        ev[W_PIN] = |pin_hit;

        // in sleep the comparator may raise a wake only when set to low power
        n.cmp_prev = i_cmp_out;
        cmp_edge = r.cmp.enable && (i_cmp_out != r.cmp_prev) && (i_cmp_out == r.cmp.rise);
        ev[W_CMP] = cmp_edge && (r.pwr.dig_on || r.cmp.low_power);

        // hardware set wins over a software clear in the same cycle
        n.pend = (r.pend & ~(pend_clr ? i_apb.pwdata[5:0] : 6'h00)) | ev;
        wake = |(r.pend & r.wake_en);

        if (wr)
        begin
            unique case (i_apb.paddr)
                A_CTRL:
                begin
                    n.ram_keep = i_apb.pwdata[B_RAM_KEEP];
                    n.osc_off = i_apb.pwdata[B_OSC_OFF];
                end
                A_WAKE_EN:  n.wake_en = i_apb.pwdata[5:0];
                A_PIN_EN:   n.pin_en = i_apb.pwdata[19:0];
                A_PIN_RISE: n.pin_rise = i_apb.pwdata[19:0];
                A_CMP_CFG:  n.cmp = i_apb.pwdata[7:0];
                A_T0_LO:    n.tc0[31:0] = i_apb.pwdata;
                A_T0_HI:    n.tc0[40:32] = i_apb.pwdata[8:0];
                A_T1_LO:    n.tc1[31:0] = i_apb.pwdata;
                A_T1_HI:    n.tc1[40:32] = i_apb.pwdata[8:0];
                A_PC_CMP:   n.pcc = i_apb.pwdata;
                // pin latches only move while awake, so sleep sees them frozen
                A_GPIO_OUT: if (!r.pwr.io_hold) n.gout = i_apb.pwdata[19:0];
                A_GPIO_PU:  if (!r.pwr.io_hold) n.gpu = i_apb.pwdata[19:0];
                default:    n.pcc = r.pcc;
            endcase
        end

        unique case (r.st)
            ST_ACTIVE:
            begin
                // mode requests take effect with the write itself
                if (wr && i_apb.paddr == A_CTRL)
                begin
                    if (i_apb.pwdata[B_DEEP])
                        n.st = ST_DEEP;
                    else if (i_apb.pwdata[B_SLEEP])
                        n.st = ST_SLEEP;
                    else if (i_apb.pwdata[B_DOZE])
                        n.st = ST_DOZE;
                end
            end
            ST_DOZE:
                if (i_irq_any)
                    n.st = ST_ACTIVE;
            ST_SLEEP:
                if (wake)
                    n.st = ST_CHK;
            ST_DEEP:
                if (|(r.pend & r.wake_en & 6'h21))
                begin
                    // cold start: nothing survives a deep sleep
                    n = SWP_STATE_RST;
                    n.st = ST_CHK;
                end
            ST_CHK:
                if (i_svm_ok)
                    n.st = ST_OSC;
            ST_OSC:
                if (i_frc_stable)
                begin
                    n.st = ST_ACTIVE;
                end
        endcase
        if (r.st == ST_DEEP && n.st == ST_CHK)
            n.from_sleep = 1'b0;
        if (r.st == ST_SLEEP)
            n.from_sleep = 1'b1;
        if (rd_status_clear(wr, i_apb.paddr))
            n.from_sleep = i_apb.pwdata[0] ? 1'b0 : n.from_sleep;

        // domain switches follow the next state so they move with it
        n.pwr = PWR_ACTIVE;
        unique case (n.st)
            ST_ACTIVE:
                n.pwr.radio_on = i_radio_req;
            ST_DOZE:
            begin
                n.pwr.cpu_doze = 1'b1;
                n.pwr.radio_on = i_radio_req;
            end
            ST_SLEEP:
            begin
                n.pwr = '0;
                // options written with the sleep request itself apply at once
                n.pwr.ram_on = n.ram_keep;
                n.pwr.slow_on = !n.osc_off;
                n.pwr.io_hold = 1'b1;
            end
            ST_DEEP:
            begin
                n.pwr = '0;
                n.pwr.io_hold = 1'b1;
            end
            ST_CHK:
            begin
                n.pwr = '0;
                n.pwr.ram_on = n.ram_keep;
                n.pwr.slow_on = 1'b1;
                n.pwr.io_hold = 1'b1;
            end
            ST_OSC:
            begin
                n.pwr = '0;
                n.pwr.ram_on = n.ram_keep;
                n.pwr.slow_on = 1'b1;
                n.pwr.frc_on = 1'b1;
                n.pwr.io_hold = 1'b1;
            end
        endcase

        // single-cycle access phase: pready is raised from the setup cycle
        n.pready = setup;
        n.pslverr = 1'b0;
        n.prdata = '0;
        if (setup)
        begin
            unique case (i_apb.paddr)
                A_CTRL:     n.prdata = {27'h0, r.osc_off, r.ram_keep, 3'h0};
                A_STATUS:   n.prdata = {22'h0, i_cmp_out, r.from_sleep, 2'h0, r.st};
                A_WAKE_EN:  n.prdata = {26'h0, r.wake_en};
                A_WAKE_PND: n.prdata = {26'h0, r.pend};
                A_PIN_EN:   n.prdata = {12'h0, r.pin_en};
                A_PIN_RISE: n.prdata = {12'h0, r.pin_rise};
                A_CMP_CFG:  n.prdata = {24'h0, r.cmp};
                A_T0_LO:    n.prdata = r.t0[31:0];
                A_T0_HI:    n.prdata = {23'h0, r.t0[40:32]};
                A_T1_LO:    n.prdata = r.t1[31:0];
                A_T1_HI:    n.prdata = {23'h0, r.t1[40:32]};
                A_PC_CMP:   n.prdata = r.pcc;
                A_GPIO_OUT: n.prdata = {12'h0, r.gout};
                A_GPIO_PU:  n.prdata = {12'h0, r.gpu};
                A_PC_CNT:   n.prdata = {r.pc1, r.pc0};
                default:    n.pslverr = 1'b1;
            endcase
        end
    end

    // status write of bit 0 acknowledges the from-sleep flag
    function automatic logic rd_status_clear(input logic w, input logic [7:0] a);
        rd_status_clear = w && (a == A_STATUS);
    endfunction : rd_status_clear

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            r <= SWP_STATE_RST;
        else
            r <= n;
    end

    // pin latches only move while awake, so sleep sees them frozen
    assign o_gpio_out = r.gout;
    assign o_gpio_pu = r.gpu;
    assign o_cmp_cfg = r.cmp;
    assign o_pwr = r.pwr;
    assign o_pready = r.pready;
    assign o_pslverr = r.pslverr;
    assign o_prdata = r.prdata;

    doze_exit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_DOZE && i_irq_any |=> r.st == ST_ACTIVE)
        else $error("doze not ended by interrupt");
    io_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP |=> $stable(o_gpio_out) && $stable(o_gpio_pu))
        else $error("pin state moved during sleep");
    ram_pwr_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP |-> o_pwr.ram_on == r.ram_keep && !o_pwr.dig_on)
        else $error("ram or logic domain wrong in sleep");
    osc_restart_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP && wake |=> o_pwr.slow_on && r.st == ST_CHK)
        else $error("slow oscillator not restarted on wake");
    no_wake_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP && !wake |=> r.st == ST_SLEEP)
        else $error("woke without enabled pending source");
    pend_keep_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !pend_clr && r.st != ST_DEEP |=> (r.pend & $past(r.pend)) == $past(r.pend))
        else $error("pending wake lost without clear");
    cpu_order_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $rose(o_pwr.cpu_rst_n) |-> $past(i_frc_stable) && $past(r.st) == ST_OSC)
        else $error("cpu released before fast oscillator stable");
    tmr_run_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.slow_tick && r.st != ST_DEEP |=> r.t0 == $past(r.t0) + 41'h1)
        else $error("wakeup counter did not advance");
    deep_off_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_DEEP |-> !o_pwr.slow_on && !o_pwr.dig_on && !o_pwr.ram_on && o_pwr.io_hold)
        else $error("domain left on in deep sleep");
    mode_onehot_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $onehot(r.st))
        else $error("mode register not one-hot");
    wake_seq_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_CHK |-> !o_pwr.frc_on && !o_pwr.cpu_rst_n && !o_pwr.dig_on)
        else $error("cpu system powered before supply check");
    sleep_mark_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP |=> r.from_sleep)
        else $error("sleep visit not recorded");
    slow_keep_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP && !r.osc_off |-> o_pwr.slow_on)
        else $error("slow oscillator stopped in sleep");
    pin_wake_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st != ST_DEEP && |pin_hit |=> r.pend[W_PIN])
        else $error("pin edge not latched as pending");
    pulse_run_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st != ST_DEEP && i_pulse[0] && !r.pc_prev[0] |=> r.pc0 == $past(r.pc0) + 16'h0001)
        else $error("pulse counter missed an edge");
    deep_exit_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_DEEP && |(r.pend & r.wake_en & 6'h21)
        |=> r.st == ST_CHK && !r.from_sleep && r.wake_en == 6'h00)
        else $error("deep sleep exit kept earlier state");
    deep_stay_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_DEEP && !(|(r.pend & r.wake_en & 6'h21)) |=> r.st == ST_DEEP)
        else $error("deep sleep left without enabled pin or comparator");
    cmp_wake_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP && !wake && cmp_edge && r.cmp.low_power && r.wake_en[W_CMP]
        |=> ##1 r.st == ST_CHK)
        else $error("comparator edge did not wake sleep");
    domains_off_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        r.st == ST_SLEEP || r.st == ST_DEEP |-> !o_pwr.dig_on && !o_pwr.radio_on)
        else $error("logic or radio domain on while asleep");
endmodule : swp_ctrl

/* File: hw/swp_pkg.sv */
// constants, carriers and state record of the sleep/wakeup power controller
// assumes a single 125 MHz clock and an apb master on the register side
package swp_pkg;
    localparam int unsigned CLK_HZ   = 125_000_000;
    localparam int unsigned SLOW_HZ  = 32_768;
    localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam logic [11:0] SLOW_DIV_LAST = 12'(SLOW_DIV - 1);

    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_STATUS   = 8'h04;
    localparam logic [7:0] A_WAKE_EN  = 8'h08;
    localparam logic [7:0] A_WAKE_PND = 8'h0c;
    localparam logic [7:0] A_PIN_EN   = 8'h10;
    localparam logic [7:0] A_PIN_RISE = 8'h14;
    localparam logic [7:0] A_CMP_CFG  = 8'h18;
    localparam logic [7:0] A_T0_LO    = 8'h1c;
    localparam logic [7:0] A_T0_HI    = 8'h20;
    localparam logic [7:0] A_T1_LO    = 8'h24;
    localparam logic [7:0] A_T1_HI    = 8'h28;
    localparam logic [7:0] A_PC_CMP   = 8'h2c;
    localparam logic [7:0] A_GPIO_OUT = 8'h30;
    localparam logic [7:0] A_GPIO_PU  = 8'h34;
    localparam logic [7:0] A_PC_CNT   = 8'h38;

    // ctrl bits: 0 doze, 1 sleep, 2 deep sleep, 3 keep ram, 4 slow osc off in sleep
    localparam int B_DOZE = 0;
    localparam int B_SLEEP = 1;
    localparam int B_DEEP = 2;
    localparam int B_RAM_KEEP = 3;
    localparam int B_OSC_OFF = 4;
    // wake source bits
    localparam int W_PIN = 0;
    localparam int W_T0 = 1;
    localparam int W_T1 = 2;
    localparam int W_PC0 = 3;
    localparam int W_PC1 = 4;
    localparam int W_CMP = 5;
    localparam int NPIN = 20;

    typedef enum logic [5:0] {
        ST_ACTIVE = 6'h01,
        ST_DOZE   = 6'h02,
        ST_SLEEP  = 6'h04,
        ST_DEEP   = 6'h08,
        ST_CHK    = 6'h10,
        ST_OSC    = 6'h20
    } swp_st_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } swp_apb_req_t;

    typedef struct packed {
        logic dig_on;
        logic ram_on;
        logic radio_on;
        logic slow_on;
        logic frc_on;
        logic cpu_rst_n;
        logic cpu_doze;
        logic io_hold;
    } swp_pwr_t;

    // comparator setup: enable, low power, negative source, positive source, hysteresis, rising edge
    typedef struct packed {
        logic       enable;
        logic       low_power;
        logic [1:0] neg_sel;
        logic       pos_sel;
        logic [1:0] hyst;
        logic       rise;
    } swp_cmp_cfg_t;

    localparam swp_pwr_t PWR_ACTIVE = '{dig_on:1'b1, ram_on:1'b1, slow_on:1'b1, frc_on:1'b1,
                                        cpu_rst_n:1'b1, default:1'b0};

    typedef struct packed {
        swp_st_t       st;
        swp_pwr_t      pwr;
        logic          ram_keep;
        logic          osc_off;
        logic          from_sleep;
        logic [5:0]    wake_en;
        logic [5:0]    pend;
        logic [19:0]   pin_en;
        logic [19:0]   pin_rise;
        logic [19:0]   pin_prev;
        logic [19:0]   gout;
        logic [19:0]   gpu;
        swp_cmp_cfg_t  cmp;
        logic          cmp_prev;
        logic [40:0]   t0;
        logic [40:0]   t1;
        logic [40:0]   tc0;
        logic [40:0]   tc1;
        logic [15:0]   pc0;
        logic [15:0]   pc1;
        logic [31:0]   pcc;
        logic [1:0]    pc_prev;
        logic [11:0]   div;
        logic          slow_tick;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } swp_state_t;

    localparam swp_state_t SWP_STATE_RST = '{st:ST_ACTIVE, pwr:PWR_ACTIVE, default:'0};
endpackage : swp_pkg

/* File: tb/swp_ctrl_tb.sv */
// self-checking bench of the sleep/wakeup controller over apb
// assumes zero-wait apb slave and the wake source model beside it
`timescale 1ns/1ps
`define CHK(a, b, m) begin comparisons++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module swp_ctrl_tb;
    import swp_pkg::*;
    logic                i_clk = 1'b0;
    logic                i_arst_n = 1'b0;
    swp_apb_req_t        apb_r = '0;
    logic                irq = 1'b0;
    logic                radio = 1'b1;
    logic                pready, pslverr, cmp, svm_ok, frc_stable;
    logic [31:0]         prdata, q;
    logic [19:0]         gpio, gout, gpu;
    logic [1:0]          pulse;
    swp_cmp_cfg_t        cmp_cfg;
    swp_pwr_t            pwr, exp_pwr;
    logic                e;
    int                  errors = 0;
    int                  comparisons = 0;
    int                  cycles = 0;

    always #4 i_clk = ~i_clk;

    swp_ctrl i_swp_ctrl (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(apb_r), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .i_gpio_in(gpio), .o_gpio_out(gout), .o_gpio_pu(gpu),
        .i_cmp_out(cmp), .o_cmp_cfg(cmp_cfg), .i_pulse(pulse), .i_irq_any(irq), .i_radio_req(radio),
        .i_svm_ok(svm_ok), .i_frc_stable(frc_stable), .o_pwr(pwr));
    swp_wake_src i_swp_wake_src (.i_clk(i_clk), .i_frc_on(pwr.frc_on), .o_gpio(gpio), .o_cmp(cmp),
        .o_pulse(pulse), .o_svm_ok(svm_ok), .o_frc_stable(frc_stable));

    task automatic close_out;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // ready is sampled at the rising edge; the task returns mid-cycle so callers see settled outputs
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                       output logic re);
        @(posedge i_clk) apb_r <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
        @(posedge i_clk) apb_r.penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        apb_r <= '0;
        @(negedge i_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic        re;
        apb(1'b1, a, d, rq, re);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] rq);
        logic re;
        apb(1'b0, a, 32'h0, rq, re);
    endtask : rd
    task automatic wait_st(input logic [5:0] s);
        logic [31:0] rq;
        int          n;
        n = 0;
        do
        begin
            rd(A_STATUS, rq);
            n++;
        end while (rq[5:0] !== s && n < 100);
        `CHK(rq[5:0], s, "state")
    endtask : wait_st

    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end

    initial
    begin
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        exp_pwr = PWR_ACTIVE;
        exp_pwr.radio_on = 1'b1;
        wait_st(6'h01);
        `CHK(pwr, exp_pwr, "reset power")
        apb(1'b0, 8'h40, 32'h0, q, e);
        `CHK(e, 1'b1, "unmapped")
        $display("test reset done");
        wr(A_CTRL, 32'h01);
        wait_st(6'h02);
        `CHK(pwr.cpu_doze, 1'b1, "doze")
        @(posedge i_clk) irq <= 1'b1;
        wait_st(6'h01);
        @(posedge i_clk) irq <= 1'b0;
        $display("test doze done");
        for (int h = 0; h < 4; h++)
        begin
            wr(A_CMP_CFG, {24'h0, 5'b11010, 2'(h), 1'b1});
            `CHK(cmp_cfg.hyst, 2'(h), "hysteresis")
        end
        rd(A_STATUS, q);
        `CHK(q[9], 1'b0, "cmp status")
        wr(A_PC_CMP, 32'h3);
        i_swp_wake_src.pulse(0, 3);
        rd(A_PC_CNT, q);
        `CHK(q[15:0], 16'h3, "pulse count")
        rd(A_WAKE_PND, q);
        `CHK(q[W_PC0], 1'b1, "pulse pend")
        $display("test pulse done");
        wr(A_GPIO_OUT, 32'h5a5a5);
        wr(A_GPIO_PU, 32'h0f0f0);
        wr(A_PIN_EN, 32'h8);
        wr(A_PIN_RISE, 32'h8);
        wr(A_WAKE_EN, 32'h1);
        wr(A_PC_CMP, 32'h5);
        wr(A_WAKE_PND, 32'h3f);
        rd(A_WAKE_PND, q);
        `CHK(q[5:0], 6'h0, "pend clear")
        wr(A_CTRL, 32'h1a);
        wait_st(6'h04);
        `CHK({pwr.dig_on, pwr.radio_on, pwr.ram_on, pwr.slow_on}, 4'b0010, "sleep domains")
        `CHK({pwr.io_hold, gout, gpu}, {1'b1, 20'h5a5a5, 20'h0f0f0}, "pin hold")
        i_swp_wake_src.pulse(0, 2);
        wait_st(6'h04);
        i_swp_wake_src.svm_set(1'b0);
        i_swp_wake_src.pin_toggle(3);
        wait_st(6'h10);
        `CHK({pwr.frc_on, pwr.cpu_rst_n}, 2'b00, "supply check first")
        i_swp_wake_src.svm_set(1'b1);
        wait_st(6'h20);
        `CHK({pwr.frc_on, pwr.cpu_rst_n}, 2'b10, "osc before cpu")
        wait_st(6'h01);
        `CHK({pwr.dig_on, pwr.slow_on, pwr.cpu_rst_n}, 3'b111, "awake")
        rd(A_WAKE_PND, q);
        `CHK({q[W_PC0], q[W_PIN]}, 2'b11, "sleep pend")
        rd(A_STATUS, q);
        `CHK(q[8], 1'b1, "from sleep")
        rd(A_PC_CNT, q);
        `CHK(q[15:0], 16'h5, "count in sleep")
        wr(A_STATUS, 32'h1);
        rd(A_STATUS, q);
        `CHK(q[8], 1'b0, "from sleep clear")
        $display("test sleep done");
        wr(A_WAKE_EN, 32'h20);
        wr(A_WAKE_PND, 32'h3f);
        wr(A_CTRL, 32'h04);
        wait_st(6'h08);
        `CHK({pwr.dig_on, pwr.ram_on, pwr.radio_on, pwr.slow_on}, 4'b0000, "deep off")
        i_swp_wake_src.pin_toggle(5);
        wait_st(6'h08);
        i_swp_wake_src.cmp_set(1'b1);
        wait_st(6'h01);
        rd(A_GPIO_OUT, q);
        `CHK(q, 32'h0, "cold state")
        rd(A_WAKE_EN, q);
        `CHK(q, 32'h0, "cold enables")
        rd(A_STATUS, q);
        `CHK(q[9:8], 2'b10, "cold status")
        $display("test deep done");
        close_out();
    end
endmodule : swp_ctrl_tb

/* File: tb/swp_wake_src.sv */
// far side of the sleep/wakeup controller: pins, comparator, pulse inputs,
// supply monitor and fast rc oscillator; assumes the bench calls its tasks
`timescale 1ns/1ps
module swp_wake_src #(
    parameter int FRC_DLY = 40
) (
    input  wire logic        i_clk,
    input  wire logic        i_frc_on,
    output logic [19:0]      o_gpio,
    output logic             o_cmp,
    output logic [1:0]       o_pulse,
    output logic             o_svm_ok,
    output logic             o_frc_stable
);
    int frc_cnt = 0;
    initial
    begin
        o_gpio = '0;
        o_cmp = 1'b0;
        o_pulse = '0;
        o_svm_ok = 1'b1;
    end
    // oscillator is only stable some time after it is switched on
    always @(posedge i_clk)
    begin
        frc_cnt <= i_frc_on ? frc_cnt + 1 : 0;
        o_frc_stable <= i_frc_on && (frc_cnt >= FRC_DLY);
    end
    task automatic pin_toggle(input int n);
        @(posedge i_clk) o_gpio[n] <= ~o_gpio[n];
    endtask : pin_toggle
    task automatic pulse(input int k, input int n);
        repeat (n)
        begin
            @(posedge i_clk) o_pulse[k] <= 1'b1;
            @(posedge i_clk) o_pulse[k] <= 1'b0;
        end
    endtask : pulse
    task automatic cmp_set(input logic v);
        @(posedge i_clk) o_cmp <= v;
    endtask : cmp_set
    task automatic svm_set(input logic v);
        @(posedge i_clk) o_svm_ok <= v;
    endtask : svm_set
endmodule : swp_wake_src
